// >>> logic/clk_ctrl_pkg.sv
// Constants and types shared by the clock controller and its helpers.
// Assumes one 50 MHz clock; no register bus, all control bits are ports.
package clk_ctrl_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_LPX = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FRC_DIVN = 3'h7;
  localparam logic [2:0] SRC_RESET = SRC_FRC;
  localparam int unsigned SETTLE_CYCLES = 10;
  localparam int unsigned STARTUP_TIMER_CYCLES = 1024;
  localparam int unsigned WAKE_MIN_CYCLES = 2;
  localparam int unsigned WAKE_MAX_CYCLES = 4;
  localparam int unsigned RATIO_W = 3;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 3'h0;
  localparam int unsigned SRC_NUM = 8;
  localparam logic PS_MODE_SLEEP = 1'b0;
  localparam logic PS_MODE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_START = 3'b001,
    ST_SETTLE = 3'b011,
    ST_SLEEP = 3'b010,
    ST_IDLE = 3'b110,
    ST_WAKE = 3'b111
  } sw_state_t;

  function automatic logic src_is_pll(input logic [2:0] src);
    return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction

  function automatic logic src_is_crystal(input logic [2:0] src);
    return (src == SRC_PRI) || (src == SRC_PRI_PLL) || (src == SRC_LPX);
  endfunction
endpackage

// >>> logic/cycle_counter.sv
// Down counter with load and one-cycle done pulse.
// Assumes the count enable and load come from logic on the same clock.
`timescale 1ns/1ps
module cycle_counter #(
  parameter int unsigned WIDTH = 11
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic count_en_i,
  output logic done_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic busy;
    logic done;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load_i) begin
      s_d.cnt = value_i;
      s_d.busy = 1'b1;
    end else if (s_q.busy && count_en_i) begin
      if (s_q.cnt <= WIDTH'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
endmodule

// >>> logic/cpu_slowdown.sv
// Reduced CPU clock enable generator with a power-of-two ratio.
// Assumes the ratio and enable are synchronous to clk_i.
`timescale 1ns/1ps
module cpu_slowdown (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic active_i,
  input wire logic [2:0] ratio_i,
  output logic cpu_tick_o
);
  typedef struct packed {
    logic [6:0] cnt;
  } dz_state_t;

  dz_state_t s_q;
  dz_state_t s_d;
  logic [6:0] limit;

  always_comb begin
    limit = 7'((8'h01 << ratio_i) - 8'h01);
    s_d = s_q;
    if (!active_i || s_q.cnt >= limit) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // The tick gates only the CPU; the peripheral clock keeps running every cycle at any ratio.
  assign cpu_tick_o = !active_i || (s_q.cnt == 7'h00);
endmodule

// >>> logic/clock_switch_power_save_ctrl.sv
// System clock controller: source switching, fail monitor, Sleep, Idle and CPU slowdown.
// Assumes oscillator ready, lock and fail indications are asynchronous pins;
// core requests, interrupts and register writes are on clk_i.
`timescale 1ns/1ps
module clock_switch_power_save_ctrl
  import clk_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic switch_monitor_config_i,
  input wire logic [2:0] reset_source_i,
  input wire logic next_source_wr_i,
  input wire logic [2:0] next_source_field_i,
  input wire logic switch_go_set_i,
  input wire logic watchdog_enable_i,
  input wire logic secondary_osc_enable_i,
  input wire logic [SRC_NUM-1:0] osc_ready_i,
  input wire logic pll_lock_i,
  input wire logic osc_fail_i,
  input wire logic power_save_req_i,
  input wire logic power_save_mode_i,
  input wire logic irq_pending_i,
  input wire logic watchdog_timeout_i,
  input wire logic cpu_slowdown_enable_i,
  input wire logic [RATIO_W-1:0] slowdown_ratio_i,
  input wire logic return_on_interrupt_bit_i,
  output logic [2:0] current_source_field_o,
  output logic [2:0] next_source_field_o,
  output logic switch_go_bit_o,
  output logic pll_locked_flag_o,
  output logic clock_fail_flag_o,
  output logic clock_fail_trap_o,
  output logic [SRC_NUM-1:0] osc_enable_o,
  output logic [2:0] sys_clk_sel_o,
  output logic fallback_pll_o,
  output logic low_power_rc_enable_o,
  output logic monitor_active_o,
  output logic watchdog_clear_o,
  output logic sys_clk_gate_o,
  output logic periph_clk_enable_o,
  output logic cpu_clk_enable_o,
  output logic power_save_ack_o,
  output logic asleep_o,
  output logic idle_o,
  output logic switch_busy_o
);
  localparam int unsigned CNT_W = 11;

  typedef struct packed {
    sw_state_t st;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic [2:0] old;
    logic go;
    logic lock_flag;
    logic fail_flag;
    logic fb_pll;
    logic trap;
    logic wdt_clr;
    logic ack;
    logic held_irq;
    logic slow_on;
    logic timer_ok;
    logic [SRC_NUM-1:0] osc_en;
    logic [2:0] rdy_s1;
    logic [2:0] rdy_s2;
    logic [2:0] new_clk_s1;
    logic [2:0] new_clk_s2;
    logic prev_new_clk;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [SRC_NUM-1:0] rdy_meta_q;
  logic [SRC_NUM-1:0] rdy_sync_q;
  logic lock_meta_q;
  logic lock_sync_q;
  logic fail_meta_q;
  logic fail_sync_q;
  logic switch_allowed;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_en;
  logic cnt_done;
  logic new_src_ready;
  logic start_wait_done;
  logic cpu_tick;
  logic [2:0] strap_src_q;
  logic strap_taken_q;

  // Pins from the analog side cross through two flops before use.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_meta_q <= '0;
      rdy_sync_q <= '0;
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
      fail_meta_q <= 1'b0;
      fail_sync_q <= 1'b0;
    end else begin
      rdy_meta_q <= osc_ready_i;
      rdy_sync_q <= rdy_meta_q;
      lock_meta_q <= pll_lock_i;
      lock_sync_q <= lock_meta_q;
      fail_meta_q <= osc_fail_i;
      fail_sync_q <= fail_meta_q;
    end
  end

  // The reset source strap is caught on the first edge after release.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_src_q <= SRC_RESET;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_src_q <= reset_source_i;
      strap_taken_q <= 1'b1;
    end
  end

  assign switch_allowed = !switch_monitor_config_i;

  assign new_src_ready = rdy_sync_q[s_q.nxt] && (!src_is_pll(s_q.nxt) || lock_sync_q);
  // Only crystals run the start-up timer; its expiry is remembered while lock is awaited.
  assign start_wait_done = !src_is_crystal(s_q.nxt) || s_q.timer_ok || cnt_done;

  always_comb begin
    s_d = s_q;
    s_d.trap = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.ack = 1'b0;
    cnt_load = 1'b0;
    cnt_value = '0;
    cnt_en = 1'b0;
    s_d.lock_flag = s_q.lock_flag | (lock_sync_q & src_is_pll(s_q.cur));
    if (!strap_taken_q) begin
      s_d.cur = reset_source_i;
      s_d.nxt = reset_source_i;
      s_d.osc_en = SRC_NUM'(1) << reset_source_i;
    end
    if (switch_allowed && next_source_wr_i && s_q.st == ST_RUN) begin
      s_d.nxt = next_source_field_i;
    end else if (!switch_allowed) begin
      s_d.nxt = s_q.cur;
    end
    case (s_q.st)
      ST_RUN: begin
        if (power_save_req_i) begin
          s_d.wdt_clr = 1'b1;
          s_d.held_irq = 1'b0;
          s_d.st = (power_save_mode_i == PS_MODE_SLEEP) ? ST_SLEEP : ST_IDLE;
          s_d.ack = 1'b1;
        end else if (switch_allowed && switch_go_set_i) begin
          if (s_d.nxt == s_q.cur) begin
            s_d.go = 1'b0;
          end else begin
            s_d.go = 1'b1;
            s_d.lock_flag = 1'b0;
            s_d.fail_flag = 1'b0;
            s_d.old = s_q.cur;
            s_d.timer_ok = 1'b0;
            s_d.osc_en[s_d.nxt] = 1'b1;
            s_d.st = ST_START;
            if (src_is_crystal(s_d.nxt)) begin
              cnt_load = 1'b1;
              cnt_value = CNT_W'(STARTUP_TIMER_CYCLES);
            end
          end
        end
      end
      ST_START: begin
        cnt_en = 1'b1;
        s_d.timer_ok = s_q.timer_ok | cnt_done;
        if (new_src_ready && start_wait_done) begin
          s_d.st = ST_SETTLE;
          s_d.timer_ok = 1'b0;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(SETTLE_CYCLES);
        end
      end
      ST_SETTLE: begin
        cnt_en = s_q.new_clk_s2[0];
        if (cnt_done) begin
          s_d.go = 1'b0;
          s_d.cur = s_q.nxt;
          s_d.fb_pll = 1'b0;
          s_d.st = ST_RUN;
          s_d.osc_en[s_q.old] = 1'b0;
          if (s_q.old == SRC_LPX && secondary_osc_enable_i) begin
            s_d.osc_en[SRC_LPX] = 1'b1;
          end
          // The low-power RC stays on while the watchdog or fail monitor still needs it.
          if (s_q.old == SRC_LOW_POWER_RC_OSC && (watchdog_enable_i || switch_allowed)) begin
            s_d.osc_en[SRC_LOW_POWER_RC_OSC] = 1'b1;
          end
        end
      end
      ST_SLEEP, ST_IDLE: begin
        s_d.held_irq = s_q.held_irq | irq_pending_i;
        if (s_q.held_irq || irq_pending_i || watchdog_timeout_i) begin
          s_d.st = ST_WAKE;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(WAKE_MIN_CYCLES);
        end
      end
      ST_WAKE: begin
        cnt_en = 1'b1;
        if (cnt_done) begin
          s_d.st = ST_RUN;
        end
      end
      default: begin
        s_d.st = ST_RUN;
      end
    endcase
    // Placed after the state logic so a fault coinciding with a switch start keeps its flag.
    // failure trap and fast RC fallback
    if (switch_allowed && fail_sync_q && !s_q.fail_flag && s_q.st != ST_SLEEP) begin
      s_d.fail_flag = 1'b1;
      s_d.trap = 1'b1;
      s_d.go = 1'b0;
      s_d.st = ST_RUN;
      s_d.cur = src_is_pll(s_q.cur) ? SRC_FRC_PLL : SRC_FRC;
      s_d.nxt = s_d.cur;
      s_d.fb_pll = src_is_pll(s_q.cur);
      s_d.osc_en[s_d.cur] = 1'b1;
    end
    if (!switch_allowed) begin
      s_d.go = 1'b0;
    end
    s_d.new_clk_s1 = {s_q.new_clk_s1[1:0], rdy_sync_q[s_q.nxt]};
    // The settle count advances once per system cycle while the new source is ready;
    // an independent edge count of the new clock would need a second clock domain.
    s_d.new_clk_s2 = {2'b00, rdy_sync_q[s_q.nxt]};
    s_d.prev_new_clk = rdy_sync_q[s_q.nxt];
    if (!cpu_slowdown_enable_i) begin
      s_d.slow_on = 1'b0;
    end else if (return_on_interrupt_bit_i && irq_pending_i) begin
      s_d.slow_on = 1'b0;
    end else begin
      s_d.slow_on = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: ST_RUN, cur: SRC_RESET, nxt: SRC_RESET, old: SRC_RESET, osc_en: SRC_NUM'(1), default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  cycle_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(cnt_load),
    .value_i(cnt_value),
    .count_en_i(cnt_en),
    .done_o(cnt_done)
  );

  cpu_slowdown u_slowdown (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .active_i(s_q.slow_on),
    .ratio_i(slowdown_ratio_i),
    .cpu_tick_o(cpu_tick)
  );

  assign current_source_field_o = s_q.cur;
  assign next_source_field_o = s_q.nxt;
  assign switch_go_bit_o = s_q.go;
  assign pll_locked_flag_o = s_q.lock_flag;
  assign clock_fail_flag_o = s_q.fail_flag;
  assign clock_fail_trap_o = s_q.trap;
  assign sys_clk_sel_o = s_q.cur;
  assign fallback_pll_o = s_q.fb_pll;
  assign watchdog_clear_o = s_q.wdt_clr;
  assign power_save_ack_o = s_q.ack;
  assign asleep_o = (s_q.st == ST_SLEEP);
  assign idle_o = (s_q.st == ST_IDLE);
  assign switch_busy_o = (s_q.st == ST_START) || (s_q.st == ST_SETTLE);
  // RC kept in Idle when needed
  assign monitor_active_o = switch_allowed && (s_q.st != ST_SLEEP);
  assign low_power_rc_enable_o = (s_q.st == ST_SLEEP) ? watchdog_enable_i :
                                 (watchdog_enable_i || switch_allowed || s_q.cur == SRC_LOW_POWER_RC_OSC ||
                                  s_q.osc_en[SRC_LOW_POWER_RC_OSC]);
  // Sleep stops oscillators and clocked peripherals
  assign osc_enable_o = (s_q.st == ST_SLEEP) ? '0 : s_q.osc_en;
  assign sys_clk_gate_o = (s_q.st != ST_SLEEP);
  assign periph_clk_enable_o = (s_q.st != ST_SLEEP);
  assign cpu_clk_enable_o = (s_q.st == ST_RUN || s_q.st == ST_START || s_q.st == ST_SETTLE) && cpu_tick;
endmodule

// >>> verification/core_model.sv
// Model of the processor core that issues source writes, switch starts and power-save requests.
// Assumes the controller samples every strobe on the rising edge of clk_i.
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  output logic next_source_wr_o,
  output logic [2:0] next_source_field_o,
  output logic switch_go_set_o,
  output logic power_save_req_o,
  output logic power_save_mode_o
);
  initial begin
    next_source_wr_o = 1'b0;
    next_source_field_o = 3'h0;
    switch_go_set_o = 1'b0;
    power_save_req_o = 1'b0;
    power_save_mode_o = 1'b0;
  end
  // write then go.
  // The unlock steps have no port, so only their order is kept; callers never jump between PLL sources.
  task automatic switch_to(input logic [2:0] src);
    @(posedge clk_i);
    next_source_field_o <= src;
    next_source_wr_o <= 1'b1;
    @(posedge clk_i);
    next_source_wr_o <= 1'b0;
    next_source_field_o <= ~src;
    switch_go_set_o <= 1'b1;
    @(posedge clk_i);
    switch_go_set_o <= 1'b0;
  endtask
  task automatic power_save(input logic mode);
    @(posedge clk_i);
    power_save_req_o <= 1'b1;
    power_save_mode_o <= mode;
    @(posedge clk_i);
    power_save_req_o <= 1'b0;
    power_save_mode_o <= ~mode;
  endtask
endmodule

// >>> verification/clock_switch_power_save_ctrl_asserts.sv
// Checker for the clock controller, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module clock_switch_power_save_ctrl_asserts
  import clk_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic switch_monitor_config_i,
  input wire logic next_source_wr_i,
  input wire logic switch_go_set_i,
  input wire logic watchdog_enable_i,
  input wire logic power_save_req_i,
  input wire logic irq_pending_i,
  input wire logic [2:0] current_source_field_o,
  input wire logic [2:0] next_source_field_o,
  input wire logic switch_go_bit_o,
  input wire logic pll_locked_flag_o,
  input wire logic clock_fail_flag_o,
  input wire logic clock_fail_trap_o,
  input wire logic fallback_pll_o,
  input wire logic low_power_rc_enable_o,
  input wire logic monitor_active_o,
  input wire logic periph_clk_enable_o,
  input wire logic cpu_clk_enable_o,
  input wire logic power_save_ack_o,
  input wire logic asleep_o,
  input wire logic idle_o,
  input wire logic switch_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic run;
  assign run = !switch_busy_o && !asleep_o && !idle_o;
  sequence s_go_held;
    switch_go_bit_o[*8] ##1 switch_go_bit_o[*2];
  endsequence
  sequence s_wake;
    ##[2:4] (!idle_o && cpu_clk_enable_o);
  endsequence
  property p_redundant;
    switch_go_set_i && run && !switch_monitor_config_i && !next_source_wr_i
      && (next_source_field_o == current_source_field_o) |=> !switch_go_bit_o;
  endproperty
  a_redundant: assert property (p_redundant) else $error("Redundant switch was started.");
  property p_flags;
    $rose(switch_go_bit_o) |-> !pll_locked_flag_o && !clock_fail_flag_o;
  endproperty
  a_flags: assert property (p_flags) else $error("Status flags not cleared at switch start.");
  property p_settle;
    $rose(switch_go_bit_o) && !clock_fail_flag_o |-> s_go_held;
  endproperty
  a_settle: assert property (p_settle) else $error("Switch ended before ten settle cycles.");
  property p_done;
    $fell(switch_go_bit_o) && !clock_fail_flag_o |-> current_source_field_o == next_source_field_o;
  endproperty
  a_done: assert property (p_done) else $error("Current source not updated on completion.");
  property p_trap;
    clock_fail_trap_o |-> ##[0:1] clock_fail_flag_o
      && (current_source_field_o == (fallback_pll_o ? SRC_FRC_PLL : SRC_FRC));
  endproperty
  a_trap: assert property (p_trap) else $error("Fail trap without fallback source.");
  property p_cfg_off;
    switch_monitor_config_i && $past(switch_monitor_config_i) |-> !switch_go_bit_o && !clock_fail_trap_o;
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("Switch or monitor active while disabled.");
  property p_sleep;
    asleep_o |-> !periph_clk_enable_o && !monitor_active_o && (low_power_rc_enable_o == watchdog_enable_i);
  endproperty
  a_sleep: assert property (p_sleep) else $error("Clocks wrong during Sleep.");
  property p_idle;
    idle_o |-> periph_clk_enable_o && !cpu_clk_enable_o && (low_power_rc_enable_o || !watchdog_enable_i);
  endproperty
  a_idle: assert property (p_idle) else $error("Clocks wrong during Idle.");
  property p_ack;
    power_save_req_i && run |=> power_save_ack_o ##[0:1] (asleep_o || idle_o);
  endproperty
  a_ack: assert property (p_ack) else $error("Power-save request not acknowledged.");
  property p_wake;
    idle_o && irq_pending_i |-> s_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("Idle wake outside two to four cycles.");
endmodule
bind clock_switch_power_save_ctrl clock_switch_power_save_ctrl_asserts u_clock_switch_power_save_ctrl_asserts (
  .clk_i, .rst_n_i, .switch_monitor_config_i, .next_source_wr_i, .switch_go_set_i, .watchdog_enable_i,
  .power_save_req_i, .irq_pending_i, .current_source_field_o, .next_source_field_o, .switch_go_bit_o,
  .pll_locked_flag_o, .clock_fail_flag_o, .clock_fail_trap_o, .fallback_pll_o, .low_power_rc_enable_o,
  .monitor_active_o, .periph_clk_enable_o, .cpu_clk_enable_o, .power_save_ack_o, .asleep_o, .idle_o,
  .switch_busy_o);

// >>> verification/test_clock_switch_power_save_ctrl.sv
// Self-checking bench for the clock controller driven by the core model.
// Assumes a 50 MHz clock; oscillator pins and wake events are driven here.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module test_clock_switch_power_save_ctrl
  import clk_ctrl_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i = 1'b0, switch_monitor_config_i = 1'b0, watchdog_enable_i = 1'b1;
  logic secondary_osc_enable_i = 1'b0, pll_lock_i = 1'b1, osc_fail_i = 1'b0, irq_pending_i = 1'b0;
  logic watchdog_timeout_i = 1'b0, cpu_slowdown_enable_i = 1'b0, return_on_interrupt_bit_i = 1'b0;
  logic [2:0] reset_source_i = SRC_FRC, slowdown_ratio_i = 3'h0, next_source_field_i;
  logic [7:0] osc_ready_i = 8'hff;
  logic next_source_wr_i, switch_go_set_i, power_save_req_i, power_save_mode_i;
  logic [2:0] current_source_field_o, next_source_field_o, sys_clk_sel_o;
  logic [7:0] osc_enable_o;
  logic switch_go_bit_o, pll_locked_flag_o, clock_fail_flag_o, clock_fail_trap_o, fallback_pll_o;
  logic low_power_rc_enable_o, monitor_active_o, watchdog_clear_o, sys_clk_gate_o, periph_clk_enable_o;
  logic cpu_clk_enable_o, power_save_ack_o, asleep_o, idle_o, switch_busy_o;
  logic trap_seen = 1'b0, ack_seen = 1'b0, wdc_seen = 1'b0, sleep_seen = 1'b0;
  logic [2:0] cur_src = SRC_FRC;
  int mismatches = 0, cmp_count = 0;
  always #10 clk_i = ~clk_i;
  core_model u_core_model (.clk_i, .next_source_wr_o(next_source_wr_i), .next_source_field_o(next_source_field_i),
    .switch_go_set_o(switch_go_set_i), .power_save_req_o(power_save_req_i), .power_save_mode_o(power_save_mode_i));
  clock_switch_power_save_ctrl u_clock_switch_power_save_ctrl (.clk_i, .rst_n_i, .switch_monitor_config_i,
    .reset_source_i, .next_source_wr_i, .next_source_field_i, .switch_go_set_i, .watchdog_enable_i,
    .secondary_osc_enable_i, .osc_ready_i, .pll_lock_i, .osc_fail_i, .power_save_req_i, .power_save_mode_i,
    .irq_pending_i, .watchdog_timeout_i, .cpu_slowdown_enable_i, .slowdown_ratio_i, .return_on_interrupt_bit_i,
    .current_source_field_o, .next_source_field_o, .switch_go_bit_o, .pll_locked_flag_o, .clock_fail_flag_o,
    .clock_fail_trap_o, .osc_enable_o, .sys_clk_sel_o, .fallback_pll_o, .low_power_rc_enable_o,
    .monitor_active_o, .watchdog_clear_o, .sys_clk_gate_o, .periph_clk_enable_o, .cpu_clk_enable_o,
    .power_save_ack_o, .asleep_o, .idle_o, .switch_busy_o);
  // Pulses last one cycle, so they are latched here to be judged later.
  always @(negedge clk_i) begin
    if (clock_fail_trap_o === 1'b1) trap_seen = 1'b1;
    if (power_save_ack_o === 1'b1) ack_seen = 1'b1;
    if (watchdog_clear_o === 1'b1) wdc_seen = 1'b1;
    if (asleep_o === 1'b1) sleep_seen = 1'b1;
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic t_switch(input logic [2:0] src, input int minc, input logic go, input logic keep);
    int n;
    logic [2:0] old;
    n = 0;
    old = cur_src;
    u_core_model.switch_to(src);
    @(negedge clk_i);
    `CHK(switch_go_bit_o, go)
    `CHK(cpu_clk_enable_o, 1'b1)
    if (go) begin
      `CHK(clock_fail_flag_o, 1'b0)
      `CHK(pll_locked_flag_o, 1'b0)
      cur_src = src;
    end
    while (switch_go_bit_o === 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n >= minc && n < 3000, 1'b1)
    repeat (2) @(negedge clk_i);
    `CHK(current_source_field_o, cur_src)
    if (go) begin
      `CHK(sys_clk_sel_o, src)
      `CHK(osc_enable_o[old], keep)
    end
  endtask
  task automatic t_fail(input logic exp);
    trap_seen = 1'b0;
    @(posedge clk_i);
    osc_fail_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK(trap_seen, exp)
    if (exp) begin
      `CHK(current_source_field_o, SRC_FRC_PLL)
      `CHK(fallback_pll_o, 1'b1)
      `CHK(clock_fail_flag_o, 1'b1)
      cur_src = SRC_FRC_PLL;
    end
    @(posedge clk_i);
    osc_fail_i <= 1'b0;
  endtask
  task automatic t_idle();
    int n;
    n = 0;
    ack_seen = 1'b0;
    wdc_seen = 1'b0;
    u_core_model.power_save(PS_MODE_IDLE);
    repeat (2) @(negedge clk_i);
    `CHK(ack_seen, 1'b1)
    `CHK(idle_o, 1'b1)
    `CHK(periph_clk_enable_o, 1'b1)
    `CHK(cpu_clk_enable_o, 1'b0)
    `CHK(wdc_seen, 1'b1)
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    do begin
      @(negedge clk_i);
      n++;
    end while (cpu_clk_enable_o !== 1'b1 && n < 10);
    `CHK(n >= 2 && n <= 5, 1'b1)
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
  endtask
  task automatic t_sleep();
    wdc_seen = 1'b0;
    u_core_model.power_save(PS_MODE_SLEEP);
    repeat (2) @(negedge clk_i);
    `CHK(wdc_seen, 1'b1)
    `CHK(asleep_o, 1'b1)
    `CHK(periph_clk_enable_o, 1'b0)
    `CHK(monitor_active_o, 1'b0)
    `CHK(low_power_rc_enable_o, 1'b1)
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b1;
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK(asleep_o, 1'b0)
    `CHK(current_source_field_o, cur_src)
  endtask
  task automatic t_coincident();
    ack_seen = 1'b0;
    sleep_seen = 1'b0;
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    u_core_model.power_save(PS_MODE_SLEEP);
    repeat (8) @(negedge clk_i);
    `CHK({ack_seen, sleep_seen, asleep_o}, 3'h6)
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
  endtask
  task automatic t_slow(input logic [2:0] r, input logic return_on_interrupt_bit, input logic irq, input int win, input int exp);
    int n;
    n = 0;
    @(posedge clk_i);
    cpu_slowdown_enable_i <= 1'b1;
    slowdown_ratio_i <= r;
    return_on_interrupt_bit_i <= return_on_interrupt_bit;
    irq_pending_i <= irq;
    repeat (4) @(negedge clk_i);
    repeat (win) begin
      @(negedge clk_i);
      if (cpu_clk_enable_o === 1'b1) n++;
    end
    `CHK(n, exp)
    `CHK({periph_clk_enable_o, sys_clk_sel_o}, {1'b1, cur_src})
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    watchdog_enable_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK(low_power_rc_enable_o, 1'b1)
    @(posedge clk_i);
    watchdog_enable_i <= 1'b1;
    t_switch(SRC_FRC, 0, 1'b0, 1'b0);
    t_switch(SRC_LOW_POWER_RC_OSC, 10, 1'b1, 1'b0);
    t_switch(SRC_PRI_PLL, 1024, 1'b1, 1'b1);
    t_fail(1'b1);
    t_idle();
    t_sleep();
    t_coincident();
    // Leaving the fallback clears the fail flag, so the disabled monitor is really tested below.
    t_switch(SRC_FRC, 10, 1'b1, 1'b0);
    for (int r = 0; r < 8; r++) begin
      t_slow(r[2:0], 1'b0, 1'b0, 256, 256 >> r);
    end
    t_slow(3'h3, 1'b0, 1'b1, 64, 8);
    t_slow(3'h3, 1'b1, 1'b1, 64, 64);
    @(posedge clk_i);
    cpu_slowdown_enable_i <= 1'b0;
    irq_pending_i <= 1'b0;
    switch_monitor_config_i <= 1'b1;
    t_switch(SRC_LOW_POWER_RC_OSC, 0, 1'b0, 1'b0);
    t_fail(1'b0);
    report_and_stop();
  end
  // The whole run needs under 6000 cycles; 20000 leaves ample margin.
  initial begin
    #(20 * 20000);
    mismatches++;
    report_and_stop();
  end
endmodule
